// *** pkg/actdet_pkg.sv ***
// Purpose: Constants for the activity/inactivity detector
// Assumes: One clock, register port with one-cycle read latency
// Notes: Offsets are byte addresses of 32-bit words
package actdet_pkg;
   // Register offsets
   localparam logic [7:0] REG_FUNC_CFG = 8'h00;
   localparam logic [7:0] REG_INACT_TIMING = 8'h04;
   localparam logic [7:0] REG_INACT_THS = 8'h08;
   localparam logic [7:0] REG_WAKE_TIMING = 8'h0C;
   localparam logic [7:0] REG_ROUTE = 8'h10;
   localparam logic [7:0] REG_ACCEL_CTRL = 8'h14;
   localparam logic [7:0] REG_WAKE_SRC = 8'h18;
   localparam logic [7:0] REG_ALL_SRC = 8'h1C;
   localparam logic [7:0] REG_POWER_STAT = 8'h20;
   // Inactivity modes
   localparam logic [1:0] INACT_OFF = 2'h0;
   localparam logic [1:0] INACT_GYRO_KEEP = 2'h1;
   localparam logic [1:0] INACT_GYRO_SLEEP = 2'h2;
   localparam logic [1:0] INACT_GYRO_DOWN = 2'h3;
   // Gyro power states reported
   localparam logic [1:0] GYRO_NORMAL = 2'h0;
   localparam logic [1:0] GYRO_SLEEP = 2'h1;
   localparam logic [1:0] GYRO_DOWN = 2'h2;
   // Low-power mode 1 code for accel power mode
   localparam logic [2:0] ACCEL_LP1 = 3'h4;
   // Sleep timing
   localparam int SLEEP_LSB_SAMPLES = 514;
   localparam int SLEEP_ZERO_SAMPLES = 18;
   // Weight shifts: threshold LSB = 7.8125 mg << shift, shift saturates at 5
   localparam logic [2:0] WEIGHT_MAX_SHIFT = 3'h5;
   // Field positions
   localparam int F_IRQ_EN = 7;
   localparam int F_FILTER_SEL = 2;
   localparam int F_LATCH_EN = 3;
   localparam int F_STATE_ON_PIN = 7;
   localparam int F_CHANGE_FLAG = 1;
   localparam int F_STATE_BIT = 0;
   // Reset values
   localparam logic [7:0] ACCEL_CTRL_RST = 8'h00;
endpackage

// *** logic/actdet_core.sv ***
// Purpose: Activity/inactivity and motion/stationary recognition on accelerometer samples
// Assumes: sample_valid_i pulses once per accelerometer output sample; axis data are signed,
//          scaled so 1 LSB = 7.8125 mg
// Notes: Rate and power overrides are outputs; stored accel control is never altered
//
// Function
// - Inactivity rate from 2-bit rate field
// - Mode field: off, keep, sleep, power-down gyro
// - Runs only with global function enable set
// - Mode 00 runs motion/stationary variant
// - Stationary leaves rates and power untouched
// - Filter select: slope or high-pass input
// - 6-bit threshold with selectable LSB weight
// - Compare magnitude, sign ignored
// - Inactivity forces low-power 1 at inactivity rate
// - Sleep duration 514 samples per LSB, 0 gives 18
// - Inactivity event lasts one sample period
// - Activity restores settings and gyro state
// - Activity duration in sample periods
// - Activity event lasts one sample period
// - Route change to pins, flag in two registers
// - Flag pulsed, latched with latch and route
// - State bit always shows present state
// - State-on-pin mode drives level, no latch
//
// Design decisions made here: the placing of the registers and the plain strobed port.
`timescale 1ns/100ps
module actdet_core #(
   parameter int DATA_W = 16
) (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   // Register port
   input wire logic [7:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [31:0] reg_rdata_o,
   // Filtered samples
   input wire logic sample_valid_i,
   input wire logic signed [DATA_W-1:0] slope_x_i,
   input wire logic signed [DATA_W-1:0] slope_y_i,
   input wire logic signed [DATA_W-1:0] slope_z_i,
   input wire logic signed [DATA_W-1:0] hp_x_i,
   input wire logic signed [DATA_W-1:0] hp_y_i,
   input wire logic signed [DATA_W-1:0] hp_z_i,
   // Power overrides
   output logic [2:0] accel_power_mode_o,
   output logic [3:0] accel_rate_o,
   output logic accel_rate_override_o,
   output logic [1:0] gyro_power_o,
   // Interrupt pins
   output logic irq_pin_a_o,
   output logic irq_pin_b_o
);
   typedef enum logic [1:0] {
      ACTDET_ACTIVE = 2'b01,
      ACTDET_INACTIVE = 2'b10
   } actdet_state_type;

   // Configuration
   logic embedded_func_irq_en;
   logic [1:0] inactivity_mode_sel;
   logic filter_source_sel;
   logic latch_enable;
   logic [1:0] inactivity_rate_sel;
   logic [2:0] threshold_weight_sel;
   logic [1:0] activity_duration;
   logic state_on_pin;
   logic [5:0] motion_threshold;
   logic [3:0] sleep_duration;
   logic pin1_state_change_route;
   logic pin2_state_change_route;
   logic [2:0] accel_power_mode;
   logic [3:0] accel_rate_sel;
   // Status
   actdet_state_type state;
   logic change_evt;
   logic state_change_flag;
   logic [13:0] sleep_cnt;
   logic [1:0] act_cnt;

   ////////////////////////////////////////////////////////////////////////
   // Magnitude compare

   function automatic logic [DATA_W-1:0] mag(input logic signed [DATA_W-1:0] v);
      mag = v[DATA_W-1] ? DATA_W'(-v) : DATA_W'(v);
   endfunction

   logic [DATA_W+5:0] ths_scaled;
   logic [2:0] wshift;
   logic signed [DATA_W-1:0] ax [3];
   logic [2:0] over_axis;
   logic any_over;
   logic [13:0] sleep_limit;
   logic running;

   always_comb begin
      wshift = (threshold_weight_sel > actdet_pkg::WEIGHT_MAX_SHIFT) ? actdet_pkg::WEIGHT_MAX_SHIFT
               : threshold_weight_sel;
      ths_scaled = (DATA_W+6)'(motion_threshold) << wshift;
   end

   assign ax[0] = filter_source_sel ? hp_x_i : slope_x_i;
   assign ax[1] = filter_source_sel ? hp_y_i : slope_y_i;
   assign ax[2] = filter_source_sel ? hp_z_i : slope_z_i;

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_axis
         assign over_axis[gi] = (DATA_W+6)'(mag(ax[gi])) > ths_scaled;
      end
   endgenerate

   assign any_over = |over_axis;
   assign running = embedded_func_irq_en;
   assign sleep_limit = (sleep_duration == 4'h0) ? 14'(actdet_pkg::SLEEP_ZERO_SAMPLES)
                        : 14'(sleep_duration * actdet_pkg::SLEEP_LSB_SAMPLES);

   ////////////////////////////////////////////////////////////////////////
   // State machine and counters

   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         state <= ACTDET_ACTIVE;
         sleep_cnt <= 14'h0000;
         act_cnt <= 2'h0;
         change_evt <= 1'b0;
      end else if (!running) begin
         state <= ACTDET_ACTIVE;
         sleep_cnt <= 14'h0000;
         act_cnt <= 2'h0;
         change_evt <= 1'b0;
      end else if (sample_valid_i) begin
         change_evt <= 1'b0;
         unique case (state)
            ACTDET_ACTIVE: begin
               act_cnt <= 2'h0;
               if (any_over) begin
                  sleep_cnt <= 14'h0000;
               end else if (sleep_cnt + 14'h0001 >= sleep_limit) begin
                  sleep_cnt <= 14'h0000;
                  state <= ACTDET_INACTIVE;
                  change_evt <= 1'b1;
               end else begin
                  sleep_cnt <= sleep_cnt + 14'h0001;
               end
            end
            ACTDET_INACTIVE: begin
               sleep_cnt <= 14'h0000;
               if (!any_over) begin
                  act_cnt <= 2'h0;
               end else if (act_cnt >= activity_duration) begin
                  act_cnt <= 2'h0;
                  state <= ACTDET_ACTIVE;
                  change_evt <= 1'b1;
               end else begin
                  act_cnt <= act_cnt + 2'h1;
               end
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Power overrides

   logic inactive_override;
   assign inactive_override = (state == ACTDET_INACTIVE) && (inactivity_mode_sel != actdet_pkg::INACT_OFF);

   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         accel_power_mode_o <= 3'h0;
         accel_rate_o <= 4'h0;
         accel_rate_override_o <= 1'b0;
         gyro_power_o <= actdet_pkg::GYRO_NORMAL;
      end else if (inactive_override) begin
         accel_power_mode_o <= actdet_pkg::ACCEL_LP1;
         accel_rate_o <= {2'h0, inactivity_rate_sel};
         accel_rate_override_o <= 1'b1;
         unique case (inactivity_mode_sel)
            actdet_pkg::INACT_GYRO_SLEEP: gyro_power_o <= actdet_pkg::GYRO_SLEEP;
            actdet_pkg::INACT_GYRO_DOWN: gyro_power_o <= actdet_pkg::GYRO_DOWN;
            default: gyro_power_o <= actdet_pkg::GYRO_NORMAL;
         endcase
      end else begin
         accel_power_mode_o <= accel_power_mode;
         accel_rate_o <= accel_rate_sel;
         accel_rate_override_o <= 1'b0;
         gyro_power_o <= actdet_pkg::GYRO_NORMAL;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Change flag and pins

   logic routed;
   logic latch_mode;
   logic src_read;
   assign routed = pin1_state_change_route | pin2_state_change_route;
   assign latch_mode = latch_enable && routed && !state_on_pin;
   assign src_read = reg_rd_i && (reg_addr_i == actdet_pkg::REG_WAKE_SRC || reg_addr_i == actdet_pkg::REG_ALL_SRC);

   // One-cycle strobe, so a read inside the event period still clears a latched flag
   logic evt_prev;
   logic evt_set;
   assign evt_set = change_evt && !evt_prev;

   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         evt_prev <= 1'b0;
      end else begin
         evt_prev <= change_evt;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         state_change_flag <= 1'b0;
      end else if (!latch_mode) begin
         state_change_flag <= change_evt;
      end else if (evt_set) begin
         state_change_flag <= 1'b1;
      end else if (src_read) begin
         state_change_flag <= 1'b0;
      end
   end

   logic pin_sig;
   assign pin_sig = state_on_pin ? (state == ACTDET_INACTIVE) : state_change_flag;

   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         irq_pin_a_o <= 1'b0;
         irq_pin_b_o <= 1'b0;
      end else begin
         irq_pin_a_o <= pin1_state_change_route & pin_sig;
         irq_pin_b_o <= pin2_state_change_route & pin_sig;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Register port

   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         embedded_func_irq_en <= 1'b0;
         inactivity_mode_sel <= actdet_pkg::INACT_OFF;
         filter_source_sel <= 1'b0;
         latch_enable <= 1'b0;
         inactivity_rate_sel <= 2'h0;
         threshold_weight_sel <= 3'h0;
         activity_duration <= 2'h0;
         state_on_pin <= 1'b0;
         motion_threshold <= 6'h00;
         sleep_duration <= 4'h0;
         pin1_state_change_route <= 1'b0;
         pin2_state_change_route <= 1'b0;
         {accel_power_mode, accel_rate_sel} <= 7'(actdet_pkg::ACCEL_CTRL_RST);
      end else if (reg_wr_i) begin
         unique case (reg_addr_i)
            actdet_pkg::REG_FUNC_CFG: begin
               embedded_func_irq_en <= reg_wdata_i[actdet_pkg::F_IRQ_EN];
               inactivity_mode_sel <= reg_wdata_i[1:0];
               filter_source_sel <= reg_wdata_i[actdet_pkg::F_FILTER_SEL];
               latch_enable <= reg_wdata_i[actdet_pkg::F_LATCH_EN];
            end
            actdet_pkg::REG_INACT_TIMING: begin
               activity_duration <= reg_wdata_i[1:0];
               inactivity_rate_sel <= reg_wdata_i[3:2];
               threshold_weight_sel <= reg_wdata_i[6:4];
               state_on_pin <= reg_wdata_i[actdet_pkg::F_STATE_ON_PIN];
            end
            actdet_pkg::REG_INACT_THS: motion_threshold <= reg_wdata_i[5:0];
            actdet_pkg::REG_WAKE_TIMING: sleep_duration <= reg_wdata_i[3:0];
            actdet_pkg::REG_ROUTE: begin
               pin1_state_change_route <= reg_wdata_i[0];
               pin2_state_change_route <= reg_wdata_i[1];
            end
            actdet_pkg::REG_ACCEL_CTRL: begin
               accel_rate_sel <= reg_wdata_i[3:0];
               accel_power_mode <= reg_wdata_i[6:4];
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         reg_rdata_o <= 32'h00000000;
      end else if (reg_rd_i) begin
         unique case (reg_addr_i)
            actdet_pkg::REG_FUNC_CFG:
               reg_rdata_o <= {24'h000000, embedded_func_irq_en, 3'h0, latch_enable, filter_source_sel,
                               inactivity_mode_sel};
            actdet_pkg::REG_INACT_TIMING:
               reg_rdata_o <= {24'h000000, state_on_pin, threshold_weight_sel,
                               inactivity_rate_sel, activity_duration};
            actdet_pkg::REG_INACT_THS: reg_rdata_o <= {26'h0000000, motion_threshold};
            actdet_pkg::REG_WAKE_TIMING: reg_rdata_o <= {28'h0000000, sleep_duration};
            actdet_pkg::REG_ROUTE:
               reg_rdata_o <= {30'h00000000, pin2_state_change_route, pin1_state_change_route};
            actdet_pkg::REG_ACCEL_CTRL: reg_rdata_o <= {25'h0000000, accel_power_mode, accel_rate_sel};
            actdet_pkg::REG_WAKE_SRC, actdet_pkg::REG_ALL_SRC:
               reg_rdata_o <= {30'h00000000, state_change_flag,
                               state == ACTDET_INACTIVE};
            actdet_pkg::REG_POWER_STAT:
               reg_rdata_o <= {24'h000000, accel_rate_override_o, gyro_power_o, accel_power_mode_o[1:0],
                               accel_rate_o[2:0]};
            default: reg_rdata_o <= 32'h00000000;
         endcase
      end else begin
         reg_rdata_o <= 32'h00000000;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Assertions

   a_override_lp1: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      inactive_override |=> accel_power_mode_o == actdet_pkg::ACCEL_LP1)
      else $error("override not low-power 1");
   a_rate_follow: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      inactive_override |=> accel_rate_o == {2'h0, $past(inactivity_rate_sel)})
      else $error("inactive rate wrong");
   a_stationary_quiet: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      inactivity_mode_sel == actdet_pkg::INACT_OFF |=> !accel_rate_override_o)
      else $error("stationary changed rate");
   a_gyro_down: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      inactive_override && inactivity_mode_sel == actdet_pkg::INACT_GYRO_DOWN
      |=> gyro_power_o == actdet_pkg::GYRO_DOWN)
      else $error("gyro not powered down");
   a_idle_off: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      !running |=> state == ACTDET_ACTIVE)
      else $error("function ran while disabled");
   a_over_restart: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      running && sample_valid_i && any_over && state == ACTDET_ACTIVE |=> sleep_cnt == 14'h0000)
      else $error("sleep count not restarted");
   a_state_pin: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      state_on_pin && pin1_state_change_route |=> irq_pin_a_o == ($past(state) == ACTDET_INACTIVE))
      else $error("pin not showing state");
   a_pulse_clear: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      !latch_mode && !change_evt ##1 !latch_mode |-> !state_change_flag)
      else $error("pulsed flag stuck");
   a_flag_hold: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      latch_mode && state_change_flag && !src_read |=> state_change_flag)
      else $error("latched flag lost before read");
   a_source_bits: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      reg_rd_i && reg_addr_i == actdet_pkg::REG_ALL_SRC
      |=> reg_rdata_o[actdet_pkg::F_STATE_BIT] == ($past(state) == ACTDET_INACTIVE)
      && reg_rdata_o[actdet_pkg::F_CHANGE_FLAG] == $past(state_change_flag))
      else $error("source bits wrong");
   a_event_hold: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      running && change_evt && !sample_valid_i |=> change_evt)
      else $error("change event dropped inside sample period");
endmodule

// *** testbench/actdet_irq_monitor.sv ***
// Purpose: Host-side model that watches the two interrupt pins
// Assumes: Pins are sampled on the system clock
// Notes: Counts rising edges and measures the last high time per pin
`timescale 1ns/100ps
module actdet_irq_monitor (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   // Interrupt pins
   input wire logic irq_pin_a_i,
   input wire logic irq_pin_b_i,
   // Observations, index 0 for pin a
   output logic [1:0][15:0] rises_o,
   output logic [1:0][15:0] width_o
);
   logic [1:0] pin;
   logic [1:0] prev;
   logic [1:0][15:0] run;
   assign pin = {irq_pin_b_i, irq_pin_a_i};
   ////////////////////////////////////////////////////////////////////////
   // Each routed change event reaches the host as one rising edge, except a return to active in state-on-pin mode
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         prev <= 2'h0;
         run <= '0;
         rises_o <= '0;
         width_o <= '0;
      end else begin
         prev <= pin;
         for (int p = 0; p < 2; p++) begin
            if (pin[p] && !prev[p]) begin
               rises_o[p] <= rises_o[p] + 16'h0001;
            end
            if (!pin[p] && prev[p]) begin
               width_o[p] <= run[p];
            end
            run[p] <= pin[p] ? run[p] + 16'h0001 : 16'h0000;
         end
      end
   end
endmodule

// *** testbench/testbench.sv ***
// Purpose: Self-checking bench for the activity/inactivity detector
// Assumes: One sample every 9 clocks, default data width
// Notes: Unselected filter carries the opposite condition on each axis
`timescale 1ns/100ps
module testbench;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic sample_valid = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic [31:0] reg_rdata;
   logic signed [15:0] sx = 16'h0, sy = 16'h0, sz = 16'h0, hx = 16'h0, hy = 16'h0, hz = 16'h0;
   logic [2:0] pmode;
   logic [3:0] prate;
   logic [1:0] gpow;
   logic povr, pin_a, pin_b;
   logic [1:0][15:0] rises, width;
   int n_mismatch = 0;
   int num_checks = 0;
   int thr, exp_r[2];
   bit lat, fs, ltc;
   bit [1:0] m, ir, ad, rt;
   bit [5:0] ths;
   bit [2:0] cm, w;
   bit [3:0] cr;
   actdet_core uut (
      .sys_clk_i(sys_clk), .rst_n_i(rst_n), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
      .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata), .sample_valid_i(sample_valid),
      .slope_x_i(sx), .slope_y_i(sy), .slope_z_i(sz), .hp_x_i(hx), .hp_y_i(hy), .hp_z_i(hz),
      .accel_power_mode_o(pmode), .accel_rate_o(prate), .accel_rate_override_o(povr),
      .gyro_power_o(gpow), .irq_pin_a_o(pin_a), .irq_pin_b_o(pin_b)
   );
   actdet_irq_monitor host (
      .sys_clk_i(sys_clk), .rst_n_i(rst_n), .irq_pin_a_i(pin_a), .irq_pin_b_i(pin_b),
      .rises_o(rises), .width_o(width)
   );
   ////////////////////////////////////////////////////////////////////////
   initial begin
      forever #25 sys_clk = ~sys_clk;
   end
   task automatic summarize;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Signed value under or over the threshold, random sign
   function automatic logic signed [15:0] val(input bit over);
      int mag;
      mag = over ? thr + 1 + $urandom_range(40) : $urandom_range(thr - 1);
      return $urandom_range(1) ? 16'(-mag) : 16'(mag);
   endfunction
   function automatic logic [15:0] exp_pwr(input bit inact);
      if (inact && m != actdet_pkg::INACT_OFF) begin
         return {6'h00, actdet_pkg::ACCEL_LP1, 2'h0, ir, 1'b1, m - 2'h1};
      end
      return {6'h00, cm, cr, 1'b0, actdet_pkg::GYRO_NORMAL};
   endfunction
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      @(negedge sys_clk);
      chk32(reg_rdata, e);
   endtask
   task automatic pwr(input bit inact);
      @(negedge sys_clk);
      chk16({6'h00, pmode, prate, povr, gpow}, exp_pwr(inact));
   endtask
   task automatic setup(input bit fe, input bit sop, input bit [3:0] sleep);
      thr = int'(ths) << ((w > 3'h5) ? 3'h5 : w);
      ltc = lat && rt != 2'h0;
      // Park the function first so every scenario starts with cleared counters
      wr(actdet_pkg::REG_FUNC_CFG, 32'h0);
      wr(actdet_pkg::REG_INACT_TIMING, {24'h0, sop, w, ir, ad});
      wr(actdet_pkg::REG_INACT_THS, {26'h0, ths});
      wr(actdet_pkg::REG_WAKE_TIMING, {28'h0, sleep});
      wr(actdet_pkg::REG_ROUTE, {30'h0, rt});
      wr(actdet_pkg::REG_ACCEL_CTRL, {25'h0, cm, cr});
      wr(actdet_pkg::REG_FUNC_CFG, {24'h0, fe, 3'h0, lat, fs, m});
   endtask
   // One sample period of 9 clocks, optionally reading both source registers
   task automatic smp(input bit over, input bit chk, input logic [1:0] e1, input logic [1:0] e2);
      logic signed [15:0] a [3];
      logic signed [15:0] b [3];
      int ax;
      ax = $urandom_range(2);
      for (int i = 0; i < 3; i++) begin
         a[i] = val(over && i == ax);
         b[i] = val(!(over && i == ax));
      end
      @(posedge sys_clk);
      sample_valid <= 1'b1;
      {sx, sy, sz} <= fs ? {b[0], b[1], b[2]} : {a[0], a[1], a[2]};
      {hx, hy, hz} <= fs ? {a[0], a[1], a[2]} : {b[0], b[1], b[2]};
      @(posedge sys_clk);
      sample_valid <= 1'b0;
      @(posedge sys_clk);
      if (chk) begin
         rd(actdet_pkg::REG_WAKE_SRC, {30'h0, e1});
         rd(actdet_pkg::REG_ALL_SRC, {30'h0, e2});
      end else begin
         repeat (4) @(posedge sys_clk);
      end
      repeat (2) @(posedge sys_clk);
   endtask
   task automatic idle(input int n);
      for (int k = 0; k < n; k++)
         smp(1'b0, 1'b0, 2'h0, 2'h0);
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (40000) @(posedge sys_clk);
      n_mismatch++;
      summarize();
   end
   initial begin
      int n;
      void'($urandom(32'hD8E6));
      repeat (2) @(posedge sys_clk);
      rst_n <= 1'b1;
      rd(actdet_pkg::REG_WAKE_SRC, 32'h0);
      pwr(1'b0);
      wr(8'h24, $urandom);
      rd(8'h24, 32'h0);
      // Function disabled: no inactivity however long the quiet
      m = 2'h3;
      ths = 6'h10;
      cm = 3'h2;
      cr = 4'hA;
      setup(1'b0, 1'b0, 4'h0);
      idle(20);
      rd(actdet_pkg::REG_WAKE_SRC, 32'h0);
      pwr(1'b0);
      for (int it = 0; it < 8; it++) begin
         m = it[1:0];
         ir = 2'(it >> 1);
         lat = it[2];
         fs = 1'($urandom_range(1));
         rt = (it == 6) ? 2'h0 : 2'($urandom_range(3, 1));
         w = 3'($urandom_range(7));
         ad = 2'($urandom_range(3));
         ths = 6'($urandom_range(63, 1));
         cm = 3'($urandom_range(7));
         cr = 4'($urandom_range(15));
         setup(1'b1, 1'b0, (it == 5) ? 4'h1 : 4'h0);
         n = (it == 5) ? actdet_pkg::SLEEP_LSB_SAMPLES : actdet_pkg::SLEEP_ZERO_SAMPLES;
         rd(actdet_pkg::REG_INACT_THS, {26'h0, ths});
         rd(actdet_pkg::REG_INACT_TIMING, {24'h0, 1'b0, w, ir, ad});
         pwr(1'b0);
         idle(n - 1);
         smp(1'b1, 1'b0, 2'h0, 2'h0);
         idle(n - 2);
         smp(1'b0, 1'b1, 2'h0, 2'h0);
         smp(1'b0, 1'b1, 2'h3, {!ltc, 1'b1});
         pwr(1'b1);
         for (int k = 0; k < ad; k++)
            smp(1'b1, k == ad - 1, 2'h1, 2'h1);
         smp(1'b1, 1'b0, 2'h0, 2'h0);
         smp(1'b0, 1'b1, {ltc, 1'b0}, 2'h0);
         pwr(1'b0);
         for (int p = 0; p < 2; p++) begin
            exp_r[p] += rt[p] ? 2 : 0;
            chk16(rises[p], 16'(exp_r[p]));
            if (!ltc && rt[p]) begin
               chk16(width[p], 16'h0009);
            end
         end
      end
      // Pins carry the state level, latch request ignored
      m = 2'h1;
      lat = 1'b1;
      rt = 2'h3;
      setup(1'b1, 1'b1, 4'h0);
      idle(20);
      @(negedge sys_clk);
      chk16({14'h0, pin_b, pin_a}, 16'h0003);
      for (int k = 0; k <= ad; k++)
         smp(1'b1, 1'b0, 2'h0, 2'h0);
      @(negedge sys_clk);
      chk16({14'h0, pin_b, pin_a}, 16'h0000);
      summarize();
   end
endmodule
